// ==== core/ars_regs.svh ====
// Function
// - Up to four shots, each with separate single-phase and three-phase dead times.
// - Dead timer starts on the chosen start condition; expiry issues the close command.
// - Close starts reclaim; pickup in reclaim starts next cycle, else sequence resets.
// - Start input runs action timer; no trip before expiry means dynamic blocked.
// - Trip input enters in-progress, drives run output, starts start-signal max timer.
// - Breaker must be ready at close; wait limited, then dynamic blocked and reset.
// - User block input holds the sequencer blocked with no reclosing.
// - General device block also blocks the sequencer.
// - Manual close disables the sequencer for a configured inhibit time.
// - Close pulse lasts its setting, cut short at once by any trip.
// - Cycle-count setting selects off or one to four shots; never exceeded.
// - Operation setting off keeps the sequencer idle with no outputs.
// - Trip-reset mode: trip deassertion starts the dead time.
// - Trip-reset mode: trip held beyond max time means dynamic blocked.
// - Breaker-open mode: no breaker open before max time means dynamic blocked.
// - Three-phase trip selects three-phase dead times, kept for the rest of the sequence.
// - Reduced dead time input ends a running dead time at once.
// - One close output serves all three phases.
`ifndef ARS_REGS_SVH
`define ARS_REGS_SVH

// Register byte offsets
`define ARS_OFF_CTRL     8'h00
`define ARS_OFF_STAT     8'h04
`define ARS_OFF_SET      8'h40

// Setting indexes, each word at ARS_OFF_SET + 4 * index
`define ARS_SI_ACT       4'h0
`define ARS_SI_MAXST     4'h1
`define ARS_SI_RECLAIM   4'h2
`define ARS_SI_CBTO      4'h3
`define ARS_SI_DYNBLK    4'h4
`define ARS_SI_MANINH    4'h5
`define ARS_SI_CLOSE     4'h6
`define ARS_SI_DT1       4'h7
`define ARS_SI_DT3       4'hb
`define ARS_NSET         15

// Control fields
`define ARS_CTRL_OP      0
`define ARS_CTRL_SRC     1
`define ARS_CTRL_CYC_LO  2
`define ARS_CTRL_CYC_HI  4
`define ARS_MAX_SHOTS    3'h4

// Reset values
`define ARS_CTRL_RST     32'h0000_0005
`define ARS_SET_RST      16'h0064

// Timing
`define ARS_CLK_NS       20
`define ARS_TICK_NS      1000000

`endif

// ==== core/ars_pkg.sv ====
package ars_pkg;

	typedef enum logic [2:0] {
		ARS_IDLE   = 3'h0,
		ARS_ACTION = 3'h1,
		ARS_RUN    = 3'h2,
		ARS_DEAD   = 3'h3,
		ARS_CBWAIT = 3'h4,
		ARS_RECL   = 3'h5,
		ARS_DYNBLK = 3'h6
	} ars_state_t;

	typedef enum logic {
		ARS_SRC_TRIP_RESET = 1'h0,
		ARS_SRC_BRK_OPEN   = 1'h1
	} ars_src_t;

endpackage

// ==== core/ars_tmr_if.sv ====
`timescale 1ns/1ps
interface ars_tmr_if #(parameter int W = 16);
	logic         tick;
	logic         load;
	logic [W-1:0] val;
	logic         expired;

	modport owner (output tick, output load, output val, input expired);
	modport timer (input tick, input load, input val, output expired);
endinterface

// ==== core/ars_tick.sv ====
`timescale 1ns/1ps
module ars_tick #(
	parameter int DIV = 50000
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic srst,
	// Millisecond enable
	output logic      tick
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

	logic [CW-1:0] cnt_q;

	// Divider producing one enable pulse per period
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else if (cnt_q == CW'(DIV - 1)) begin
			cnt_q <= '0;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick  <= 1'b0;
		end
	end
endmodule

// ==== core/ars_timer.sv ====
`timescale 1ns/1ps
module ars_timer #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic srst,
	// Timer control
	ars_tmr_if.timer  t
);
	logic [W-1:0] cnt_q;
	logic         arm_q;

	// Loadable down-counter in tick units
	// First tick after a load is partial and skipped, so N lasts N to N+1 ms
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cnt_q <= '0;
			arm_q <= 1'b0;
		end else if (t.load) begin
			cnt_q <= t.val;
			arm_q <= 1'b0;
		end else if (t.tick && cnt_q != '0) begin
			if (arm_q) begin
				cnt_q <= cnt_q - 1'b1;
			end else begin
				arm_q <= 1'b1;
			end
		end
	end

	assign t.expired = (cnt_q == '0);
endmodule

// ==== core/ars_top.sv ====
`timescale 1ns/1ps
`include "ars_regs.svh"
module ars_top #(
	parameter int TICK_CYC = `ARS_TICK_NS / `ARS_CLK_NS,
	parameter int TW       = 16
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Protection and breaker status
	input  wire logic        protection_start_in,
	input  wire logic        reclose_trip_in,
	input  wire logic        three_phase_trip_in,
	input  wire logic        breaker_open_in,
	input  wire logic        breaker_ready_in,
	input  wire logic        reduced_dead_time_in,
	// Blocking
	input  wire logic        block_in,
	input  wire logic        device_block_in,
	input  wire logic        manual_close_in,
	// Sequencer outputs
	output logic             close_out,
	output logic             in_progress_out,
	output logic             dyn_blocked_out
);

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  sel
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Registers
	logic [31:0]         ctrl_q;
	logic [TW-1:0]       set_q [`ARS_NSET];
	logic                ack_q;
	logic [31:0]         dat_q;
	logic [31:0]         rd_data;

	// Sequencer state
	ars_pkg::ars_state_t state_q;
	ars_pkg::ars_state_t state_d;
	logic [2:0]          cycle_q;
	logic [2:0]          cycle_d;
	logic                tph_q;
	logic                tph_d;
	logic                close_q;
	logic                run_q;
	logic                dynb_q;

	// Timer control
	logic                tick;
	logic                seq_load;
	logic [TW-1:0]       seq_val;
	logic                pulse_load;

	// Decoded settings and conditions
	logic                op_on;
	ars_pkg::ars_src_t   src_sel;
	logic [2:0]          cyc_set;
	logic [2:0]          shot_lim;
	logic                inhibit;
	logic                enabled;
	logic                start_cond;
	logic [3:0]          dt_idx;

	ars_tmr_if #(.W(TW)) seq_t ();
	ars_tmr_if #(.W(TW)) pulse_t ();
	ars_tmr_if #(.W(TW)) inh_t ();

	ars_tick #(.DIV(TICK_CYC)) u_tick (
		.core_clk (core_clk),
		.srst     (srst),
		.tick     (tick)
	);

	ars_timer #(.W(TW)) u_seq_tmr (
		.core_clk (core_clk),
		.srst     (srst),
		.t        (seq_t.timer)
	);

	ars_timer #(.W(TW)) u_pulse_tmr (
		.core_clk (core_clk),
		.srst     (srst),
		.t        (pulse_t.timer)
	);

	ars_timer #(.W(TW)) u_inh_tmr (
		.core_clk (core_clk),
		.srst     (srst),
		.t        (inh_t.timer)
	);

	// Timer hookup, all counting milliseconds
	assign seq_t.tick   = tick;
	assign seq_t.load   = seq_load;
	assign seq_t.val    = seq_val;
	assign pulse_t.tick = tick;
	assign pulse_t.load = pulse_load;
	assign pulse_t.val  = set_q[`ARS_SI_CLOSE];
	assign inh_t.tick   = tick;
	assign inh_t.load   = manual_close_in;
	assign inh_t.val    = set_q[`ARS_SI_MANINH];

	// Setting decode
	assign op_on    = ctrl_q[`ARS_CTRL_OP];
	assign src_sel  = ars_pkg::ars_src_t'(ctrl_q[`ARS_CTRL_SRC]);
	assign cyc_set  = ctrl_q[`ARS_CTRL_CYC_HI:`ARS_CTRL_CYC_LO];
	assign shot_lim = (cyc_set > `ARS_MAX_SHOTS) ? `ARS_MAX_SHOTS : cyc_set;

	// Inhibit runs from manual close until its time has elapsed
	assign inhibit = manual_close_in || !inh_t.expired;

	// Any block, manual inhibit or operation off forces idle
	assign enabled = op_on && !block_in && !device_block_in && !inhibit && cyc_set != 3'h0;

	// Dead time start condition per start source
	assign start_cond = (src_sel == ars_pkg::ARS_SRC_TRIP_RESET) ? !reclose_trip_in : breaker_open_in;

	// Dead time per shot and fault type
	assign dt_idx = (tph_q || three_phase_trip_in) ?
		(`ARS_SI_DT3 + {2'h0, cycle_q[1:0]}) : (`ARS_SI_DT1 + {2'h0, cycle_q[1:0]});

	// Sequencer decisions
	always_comb begin
		state_d    = state_q;
		cycle_d    = cycle_q;
		tph_d      = tph_q || (three_phase_trip_in && state_q != ars_pkg::ARS_IDLE);
		seq_load   = 1'b0;
		seq_val    = '0;
		pulse_load = 1'b0;
		case (state_q)
			ars_pkg::ARS_IDLE,
			ars_pkg::ARS_RECL: begin
				if (reclose_trip_in) begin
					// Trip enters in-progress and starts max-time timer
					state_d  = ars_pkg::ARS_RUN;
					seq_load = 1'b1;
					seq_val  = set_q[`ARS_SI_MAXST];
					tph_d    = tph_q || three_phase_trip_in;
				end else if (protection_start_in) begin
					// Pickup starts the action timer
					state_d  = ars_pkg::ARS_ACTION;
					seq_load = 1'b1;
					seq_val  = set_q[`ARS_SI_ACT];
				end else if (state_q == ars_pkg::ARS_RECL && seq_t.expired) begin
					// Reclaim over with no pickup, next fault begins at cycle one
					state_d = ars_pkg::ARS_IDLE;
					cycle_d = 3'h0;
					tph_d   = 1'b0;
				end
			end
			ars_pkg::ARS_ACTION: begin
				if (reclose_trip_in) begin
					state_d  = ars_pkg::ARS_RUN;
					seq_load = 1'b1;
					seq_val  = set_q[`ARS_SI_MAXST];
					tph_d    = tph_q || three_phase_trip_in;
				end else if (seq_t.expired) begin
					// No trip within action time
					state_d  = ars_pkg::ARS_DYNBLK;
					seq_load = 1'b1;
					seq_val  = set_q[`ARS_SI_DYNBLK];
				end
			end
			ars_pkg::ARS_RUN: begin
				if (start_cond) begin
					if (cycle_q >= shot_lim) begin
						// Shot budget spent
						state_d  = ars_pkg::ARS_DYNBLK;
						seq_load = 1'b1;
						seq_val  = set_q[`ARS_SI_DYNBLK];
					end else begin
						// Start condition starts the dead timer
						state_d  = ars_pkg::ARS_DEAD;
						seq_load = 1'b1;
						seq_val  = set_q[dt_idx];
					end
				end else if (seq_t.expired) begin
					// Trip too long or breaker never opened
					state_d  = ars_pkg::ARS_DYNBLK;
					seq_load = 1'b1;
					seq_val  = set_q[`ARS_SI_DYNBLK];
				end
			end
			ars_pkg::ARS_DEAD: begin
				// Dead time end or reduced dead time
				if (seq_t.expired || reduced_dead_time_in) begin
					if (breaker_ready_in) begin
						// Close and reclaim start together
						state_d    = ars_pkg::ARS_RECL;
						seq_load   = 1'b1;
						seq_val    = set_q[`ARS_SI_RECLAIM];
						pulse_load = 1'b1;
						cycle_d    = cycle_q + 3'h1;
					end else begin
						state_d  = ars_pkg::ARS_CBWAIT;
						seq_load = 1'b1;
						seq_val  = set_q[`ARS_SI_CBTO];
					end
				end
			end
			ars_pkg::ARS_CBWAIT: begin
				if (breaker_ready_in) begin
					state_d    = ars_pkg::ARS_RECL;
					seq_load   = 1'b1;
					seq_val    = set_q[`ARS_SI_RECLAIM];
					pulse_load = 1'b1;
					cycle_d    = cycle_q + 3'h1;
				end else if (seq_t.expired) begin
					// Breaker never ready within supervision time
					state_d  = ars_pkg::ARS_DYNBLK;
					seq_load = 1'b1;
					seq_val  = set_q[`ARS_SI_DYNBLK];
				end
			end
			ars_pkg::ARS_DYNBLK: begin
				if (seq_t.expired) begin
					// Blocking time over, clear and return
					state_d = ars_pkg::ARS_IDLE;
					cycle_d = 3'h0;
					tph_d   = 1'b0;
				end
			end
			default: begin
				state_d = ars_pkg::ARS_IDLE;
				cycle_d = 3'h0;
				tph_d   = 1'b0;
			end
		endcase
	end

	// Sequencer state update
	always_ff @(posedge core_clk) begin
		if (srst || !enabled) begin
			state_q <= ars_pkg::ARS_IDLE;
			cycle_q <= 3'h0;
			tph_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			cycle_q <= cycle_d;
			tph_q   <= tph_d;
		end
	end

	// Single three-phase close pulse
	always_ff @(posedge core_clk) begin
		if (srst || !enabled) begin
			close_q <= 1'b0;
		end else if (pulse_load) begin
			close_q <= 1'b1;
		end else if (reclose_trip_in || pulse_t.expired) begin
			close_q <= 1'b0;
		end
	end

	// Status outputs
	always_ff @(posedge core_clk) begin
		if (srst) begin
			run_q  <= 1'b0;
			dynb_q <= 1'b0;
		end else begin
			run_q  <= enabled && (state_q == ars_pkg::ARS_RUN || state_q == ars_pkg::ARS_DEAD ||
				state_q == ars_pkg::ARS_CBWAIT || state_q == ars_pkg::ARS_RECL);
			dynb_q <= enabled && state_q == ars_pkg::ARS_DYNBLK;
		end
	end

	assign close_out       = close_q;
	assign in_progress_out = run_q;
	assign dyn_blocked_out = dynb_q;

	// Register read mux
	always_comb begin
		rd_data = 32'h0000_0000;
		if (wb_adr_i == `ARS_OFF_CTRL) begin
			rd_data = ctrl_q;
		end else if (wb_adr_i == `ARS_OFF_STAT) begin
			rd_data = {22'h0, inhibit, tph_q, close_q, run_q, cycle_q, state_q};
		end else if (wb_adr_i >= `ARS_OFF_SET && wb_adr_i[1:0] == 2'h0 &&
			wb_adr_i[5:2] < 4'(`ARS_NSET) && wb_adr_i[7:6] == 2'h1) begin
			rd_data = {{(32-TW){1'b0}}, set_q[wb_adr_i[5:2]]};
		end
	end

	// Wishbone handshake, one wait state
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
			dat_q <= (wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i) ? rd_data : 32'h0000_0000;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// Control register write
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctrl_q <= `ARS_CTRL_RST;
		end else if (wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_adr_i == `ARS_OFF_CTRL) begin
			ctrl_q <= lane_merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_001f;
		end
	end

	// Setting writes, one timer value per word
	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int i = 0; i < `ARS_NSET; i++) begin
				set_q[i] <= `ARS_SET_RST;
			end
		end else if (wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_adr_i[7:6] == 2'h1 &&
			wb_adr_i[1:0] == 2'h0 && wb_adr_i[5:2] < 4'(`ARS_NSET)) begin
			set_q[wb_adr_i[5:2]] <= TW'(lane_merge({{(32-TW){1'b0}}, set_q[wb_adr_i[5:2]]},
				wb_dat_i, wb_sel_i));
		end
	end

endmodule

// ==== tb/ars_top_asserts.sv ====
`timescale 1ns/1ps
module ars_top_asserts (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        srst,
	// Wishbone
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Sequencer inputs
	input wire logic        reclose_trip_in,
	input wire logic        breaker_ready_in,
	input wire logic        block_in,
	input wire logic        device_block_in,
	input wire logic        manual_close_in,
	// Sequencer outputs
	input wire logic        close_out,
	input wire logic        in_progress_out,
	input wire logic        dyn_blocked_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");
	property p_ack_lat; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_lat: assert property (p_ack_lat) else $error("ack not one cycle after request");
	property p_dat_zero; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	a_dat_zero: assert property (p_dat_zero) else $error("read data not zero outside ack");
	property p_block; block_in ##1 block_in |=> !close_out && !in_progress_out && !dyn_blocked_out; endproperty
	a_block: assert property (p_block) else $error("output while user block");
	property p_dev_block; device_block_in [*2] |=> !close_out && !in_progress_out; endproperty
	a_dev_block: assert property (p_dev_block) else $error("output while device block");
	property p_manual; manual_close_in [*2] |=> !close_out && !in_progress_out; endproperty
	a_manual: assert property (p_manual) else $error("output while manual close");
	property p_trip_cut; close_out && reclose_trip_in |=> !close_out; endproperty
	a_trip_cut: assert property (p_trip_cut) else $error("close not cut by trip");
	property p_run_cause; $rose(in_progress_out) |-> $past(reclose_trip_in, 2); endproperty
	a_run_cause: assert property (p_run_cause) else $error("run without trip");
	property p_close_ready; $rose(close_out) |-> $past(breaker_ready_in); endproperty
	a_close_ready: assert property (p_close_ready) else $error("close without breaker ready");
	property p_dyn_noclose; dyn_blocked_out |-> !close_out; endproperty
	a_dyn_noclose: assert property (p_dyn_noclose) else $error("close while dynamic blocked");
	property p_dyn_exit; $fell(dyn_blocked_out) |-> !in_progress_out && !close_out; endproperty
	a_dyn_exit: assert property (p_dyn_exit) else $error("not idle after dynamic block");

	c_close: cover property ($rose(close_out));
	c_dyn: cover property ($rose(dyn_blocked_out));
	c_cut: cover property (close_out && reclose_trip_in);
endmodule

// ==== tb/ars_prot_model.sv ====
`timescale 1ns/1ps
module ars_prot_model (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// Bench control
	input  wire logic        fault,
	input  wire logic        open_en,
	input  wire logic [15:0] trip_cyc,
	// Breaker command
	input  wire logic        close_out,
	// Status to the sequencer
	output logic             protection_start_in,
	output logic             reclose_trip_in,
	output logic             breaker_open_in
);
	logic        fault_q;
	logic [15:0] cnt_q;

	// Start follows the fault, trip held for trip_cyc cycles
	always_ff @(posedge core_clk) begin
		if (srst) begin
			protection_start_in <= 1'b0;
			reclose_trip_in     <= 1'b0;
			fault_q             <= 1'b0;
			cnt_q               <= 16'h0;
		end else begin
			protection_start_in <= fault;
			fault_q             <= fault;
			if (fault && !fault_q && trip_cyc != 16'h0) begin
				reclose_trip_in <= 1'b1;
				cnt_q           <= trip_cyc;
			end else if (cnt_q != 16'h0) begin
				cnt_q           <= cnt_q - 16'h1;
				reclose_trip_in <= cnt_q != 16'h1;
			end
		end
	end

	// Poles open after the trip, closed by the close command
	always_ff @(posedge core_clk) begin
		if (srst || close_out)
			breaker_open_in <= 1'b0;
		else if (reclose_trip_in && open_en)
			breaker_open_in <= 1'b1;
	end
endmodule

// ==== tb/auto_reclose_sequencer_bench.sv ====
`timescale 1ns/1ps
module auto_reclose_sequencer_bench;
	localparam int TK = 10;
	localparam int ST [15] = '{5, 20, 30, 5, 5, 5, 3, 4, 5, 6, 7, 2, 2, 2, 2};
	logic core_clk = 0, srst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
	logic [7:0]  wb_adr_i = 8'h0;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
	logic three_phase_trip_in = 0, breaker_ready_in = 1, reduced_dead_time_in = 0;
	logic block_in = 0, device_block_in = 0, manual_close_in = 0, fault = 0, open_en = 0;
	logic close_out, in_progress_out, dyn_blocked_out, protection_start_in, reclose_trip_in, breaker_open_in;
	logic [15:0] trip_cyc = 16'h0;
	int error_cnt = 0, n_checks = 0, c, n, j, k;
	wire [4:0] ob = {breaker_open_in, reclose_trip_in, dyn_blocked_out, in_progress_out, close_out};

	ars_top #(.TICK_CYC(TK)) dut (.*);
	ars_prot_model pm (.core_clk, .srst, .fault, .open_en, .trip_cyc, .close_out,
		.protection_start_in, .reclose_trip_in, .breaker_open_in);

	initial forever #10 core_clk = ~core_clk;

	task give_verdict();
		if (error_cnt == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task dchk(input int cy, input int ms);
		chk(32'(cy >= TK * ms - 2 && cy <= TK * ms + 24), 32'h1);
	endtask

	task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int i;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		for (i = 0; i < 50; i++) begin
			@(posedge core_clk);
			if (wb_ack_o === 1'b1)
				break;
		end
		if (i == 50) begin
			error_cnt++;
			give_verdict();
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask

	task wt(input int s, input logic lv, input int lim, input bit must, output int cy);
		for (cy = 0; cy < lim; cy++) begin
			@(negedge core_clk);
			if (ob[s] === lv)
				break;
		end
		if (must && cy == lim) begin
			error_cnt++;
			give_verdict();
		end
	endtask

	task flt(input logic [15:0] tc);
		@(posedge core_clk);
		fault    <= 1'b1;
		trip_cyc <= tc;
		@(posedge core_clk);
		fault    <= 1'b0;
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		wb(1'b0, 8'h00, 32'h0, r);
		chk(r, 32'h0000_0005);
		wb(1'b0, 8'h44, 32'h0, r);
		chk(r, 32'h0000_0064);
		wb(1'b0, 8'h24, 32'h0, r);
		chk(r, 32'h0);
		wb(1'b1, 8'h00, 32'hffff_ffff, r);
		wb(1'b0, 8'h00, 32'h0, r);
		chk(r, 32'h0000_001f);
		foreach (ST[i]) wb(1'b1, 8'h40 + 8'(4 * i), 32'(ST[i]), r);
		wb(1'b1, 8'h00, 32'h0000_0011, r);
		// Four shots, each later trip cutting the close pulse
		for (j = 0; j < 5; j++) begin
			flt(16'h14);
			if (j == 0)
				wt(1, 1'b1, 5, 1'b1, c);
			else
				wt(0, 1'b0, 4, 1'b1, c);
			wt(3, 1'b0, 40, 1'b1, c);
			if (j < 4) begin
				wt(0, 1'b1, 120, 1'b1, c);
				dchk(c, ST[7 + j]);
			end
		end
		wt(2, 1'b1, 10, 1'b1, c);
		wt(2, 1'b0, 80, 1'b1, c);
		dchk(c, ST[4]);
		chk(32'(in_progress_out), 32'h0);
		wb(1'b0, 8'h04, 32'h0, r);
		chk(r, 32'h0);
		flt(16'h0);
		wt(2, 1'b1, 100, 1'b1, c);
		dchk(c, ST[0]);
		wt(2, 1'b0, 100, 1'b1, c);
		flt(16'he6);
		wt(2, 1'b1, 300, 1'b1, c);
		dchk(c, ST[1]);
		wt(2, 1'b0, 100, 1'b1, c);
		@(posedge core_clk);
		breaker_ready_in <= 1'b0;
		flt(16'h14);
		wt(3, 1'b0, 40, 1'b1, c);
		wt(2, 1'b1, 200, 1'b1, c);
		dchk(c, ST[7] + ST[3]);
		@(posedge core_clk);
		breaker_ready_in    <= 1'b1;
		three_phase_trip_in <= 1'b1;
		wt(2, 1'b0, 100, 1'b1, c);
		flt(16'h14);
		wt(3, 1'b0, 40, 1'b1, c);
		wt(0, 1'b1, 100, 1'b1, c);
		dchk(c, ST[11]);
		wt(0, 1'b0, 60, 1'b1, c);
		dchk(c, ST[6]);
		wt(1, 1'b0, 400, 1'b1, n);
		dchk(c + n, ST[2]);
		@(posedge core_clk);
		three_phase_trip_in  <= 1'b0;
		reduced_dead_time_in <= 1'b1;
		flt(16'h14);
		wt(3, 1'b0, 40, 1'b1, c);
		wt(0, 1'b1, 20, 1'b1, c);
		chk(32'(c < 6), 32'h1);
		@(posedge core_clk);
		reduced_dead_time_in <= 1'b0;
		wt(1, 1'b0, 400, 1'b1, c);
		wb(1'b1, 8'h00, 32'h0000_0013, r);
		flt(16'h14);
		wt(2, 1'b1, 300, 1'b1, c);
		dchk(c, ST[1]);
		wt(2, 1'b0, 100, 1'b1, c);
		@(posedge core_clk);
		open_en <= 1'b1;
		flt(16'h14);
		wt(4, 1'b1, 5, 1'b1, c);
		wt(0, 1'b1, 100, 1'b1, c);
		dchk(c, ST[7]);
		wt(1, 1'b0, 400, 1'b1, c);
		wb(1'b1, 8'h00, 32'h0000_0011, r);
		open_en <= 1'b0;
		// Each blocking cause in turn, then released
		for (k = 0; k < 5; k++) begin
			@(posedge core_clk);
			case (k)
				0: block_in <= 1'b1;
				1: device_block_in <= 1'b1;
				2: manual_close_in <= 1'b1;
				3: wb(1'b1, 8'h00, 32'h0000_0010, r);
				default: wb(1'b1, 8'h00, 32'h0000_0001, r);
			endcase
			flt(16'h14);
			wt(1, 1'b1, 60, 1'b0, c);
			chk(32'(c == 60 && close_out === 1'b0 && dyn_blocked_out === 1'b0), 32'h1);
			wb(1'b1, 8'h00, 32'h0000_0011, r);
			block_in        <= 1'b0;
			device_block_in <= 1'b0;
			manual_close_in <= 1'b0;
			repeat (80) @(posedge core_clk);
		end
		give_verdict();
	end
endmodule

bind ars_top ars_top_asserts u_chk (.*);
